// [rtl/pisw_pkg.sv]
/*
 * Package for the peripheral interrupt and slave window block: register
 * indices, field positions, reset values, carrier structs and state types.
 * Assumes an APB master on the local clock; no other package is needed.
 */
package pisw_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [31:0] IDX_SCSI_IRQ = 32'hfffe_102a;
    localparam logic [31:0] IDX_SLAVE_WIN = 32'hfffe_102b;
    localparam logic [31:0] IDX_SOFT_ONE = 32'hfffe_102c;
    localparam logic [31:0] IDX_VEC_BASE = 32'hfffe_102d;
    localparam logic [31:0] IDX_SOFT_TWO = 32'hfffe_102e;
    localparam logic [31:0] IDX_REVISION = 32'hfffe_102f;

    // ==========================================================
    // Field positions
    localparam int LVL_LSB = 0;
    localparam int EN_BIT = 3;
    localparam int DRV_BIT = 4;
    localparam int SENSE_BIT = 5;
    localparam int RST_ST_BIT = 6;
    localparam int STAT_BIT = 7;
    localparam int WIN_LSB = 0;
    localparam int RMC_WAIT_BIT = 5;
    localparam int NET_LSB = 6;
    localparam int VBASE_LSB = 4;

    // ==========================================================
    // Reset values, codes and sizes
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] REVISION_LEVEL = 8'h00;
    localparam logic [3:0] CODE_PWR_FAIL = 4'h0;
    localparam logic [3:0] CODE_BUS_ERR = 4'h1;
    localparam logic [3:0] CODE_ABORT = 4'h2;
    localparam logic [3:0] CODE_SERIAL = 4'h3;
    localparam logic [3:0] CODE_NETWORK = 4'h4;
    localparam logic [3:0] CODE_SCSI = 4'h5;
    localparam logic [3:0] CODE_SCSI_DMA = 4'h6;
    localparam logic [3:0] CODE_PRINTER = 4'h7;
    localparam logic [3:0] CODE_TICK_ONE = 4'h8;
    localparam logic [3:0] CODE_TICK_TWO = 4'h9;
    localparam logic [3:0] CODE_SOFT_ONE = 4'ha;
    localparam logic [3:0] CODE_SOFT_TWO = 4'hb;
    // Onboard memory is 4 MB: one window step is 2**22 bytes
    localparam int MEM_SHIFT = 22;
    localparam logic [31:0] SIXTEEN_MB = 32'h0100_0000;
    localparam logic [4:0] STD_WIN_LIMIT = 5'(SIXTEEN_MB >> MEM_SHIFT);

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pisw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pisw_apb_rsp_t;

    typedef struct packed {
        logic start;
        logic first_to_vme;
        logic vme_cycle;
        logic active;
        logic granted;
    } pisw_rmc_req_t;

    typedef enum logic [1:0] {RMC_IDLE, RMC_LOCAL, RMC_ACQUIRE, RMC_HELD} pisw_rmc_state_t;

endpackage

// [rtl/pisw_top.sv]
/*
 * Peripheral interrupt control and slave window block: SCSI port interrupt
 * with bus reset drive and sense, two software interrupts, vector base,
 * revision, slave DRAM window, network DMA section and RMC mastership policy.
 * Assumes an APB master on pclk; SCSI inputs are asynchronous, all other
 * inputs come from logic on pclk.
 */
//
// Summary of operation
// - SCSI level field sets request priority; level zero requests nothing.
// - SCSI enable gates its interrupt; enable, level, drive clear at reset.
// - Drive bit set actively asserts the SCSI bus reset line, else undriven.
// - Sense bit reads one while the SCSI bus reset line is active.
// - Reset status sets on rising edge of enable AND bus reset.
// - Reset status clears on write one, disable or reset, until new edge.
// - Port status is reset status OR chip interrupt, requesting at level.
// - Window field places DRAM at field times memory size; resets zero.
// - Base below 16 MB answers standard and extended modifiers, else extended.
// - Whole slave window register resets to zero.
// - Wait bit set: obtain bus mastership before any locked sequence.
// - Wait bit clear: wait for mastership at the first remote cycle of the sequence.
// - Mastership gained in a locked sequence is held until it finishes.
// - Two network bits supply upper DMA address, picking a 16 MB section.
// - Each software interrupt has a level field; zero requests nothing.
// - Software enable alone raises the interrupt; status mirrors enable.
// - Vector is programmable base nibble over source code nibble.
// - Source codes run 0 to 11 from power fail to software two.
// - Read-only revision register reports the controller revision.
`timescale 1ns/1ps

module pisw_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire pisw_pkg::pisw_apb_req_t apb_req,
    output pisw_pkg::pisw_apb_rsp_t apb_rsp,
    input wire logic scsi_rst_in,
    input wire logic scsi_chip_irq,
    output logic scsi_rst_out,
    output logic scsi_rst_oe,
    output logic [2:0] irq_level,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    output logic iack_done,
    output logic iack_hit,
    output logic [7:0] iack_vector,
    input wire logic vme_valid,
    input wire logic vme_am_ext,
    input wire logic [31:0] vme_addr,
    output logic slave_hit,
    input wire logic [23:0] net_dma_addr,
    output logic [25:0] net_dma_local_addr,
    input wire pisw_pkg::pisw_rmc_req_t rmc,
    output logic vme_bus_request,
    output logic rmc_go
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] scsi_lvl;
        logic scsi_en;
        logic scsi_drv;
        logic scsi_rst_st;
        logic cond_prev;
        logic [1:0] rst_sync;
        logic [1:0] chip_sync;
        logic [4:0] win;
        logic rmc_wait;
        logic [1:0] net_sec;
        logic [2:0] sw1_lvl;
        logic sw1_en;
        logic [2:0] sw2_lvl;
        logic sw2_en;
        logic [3:0] vbase;
        pisw_pkg::pisw_rmc_state_t rmc_st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] irq_level;
        logic iack_done;
        logic iack_hit;
        logic [7:0] iack_vector;
        logic rst_oe;
        logic slave_hit;
        logic [25:0] net_addr;
        logic bus_req;
        logic rmc_go;
    } pisw_state_t;

    pisw_state_t s_r;
    pisw_state_t s_nxt;

    // ==========================================================
    // Helpers
    function automatic logic reg_hit(input logic [11:0] addr, input logic [31:0] idx);
        reg_hit = (addr[11:2] == idx[9:0]);
    endfunction

    function automatic logic [2:0] lvl_max(input logic [2:0] a, input logic [2:0] b);
        lvl_max = (a > b) ? a : b;
    endfunction

    // Level requested by a source, zero when it is idle or unprogrammed
    function automatic logic [2:0] src_level(input logic req, input logic [2:0] lvl);
        src_level = req ? lvl : 3'h0;
    endfunction

    // Live status views used by reads, requests and acknowledge
    logic sense;
    logic port_stat;
    logic scsi_req;
    logic sw1_req;
    logic sw2_req;
    logic wr;
    logic cond;
    assign sense = s_r.rst_sync[1];
    assign port_stat = s_r.scsi_rst_st | s_r.chip_sync[1];
    assign scsi_req = s_r.scsi_en && port_stat && (s_r.scsi_lvl != 3'h0);
    assign sw1_req = s_r.sw1_en && (s_r.sw1_lvl != 3'h0);
    assign sw2_req = s_r.sw2_en && (s_r.sw2_lvl != 3'h0);
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_r.pready;
    assign cond = s_r.scsi_en && sense;

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] rd;
        logic mapped;
        logic [4:0] std_win;
        rd = 8'h00;
        mapped = 1'b1;
        std_win = 5'h00;
        s_nxt = s_r;

        // Pin inputs pass two flops before anything reads them
        s_nxt.rst_sync = {s_r.rst_sync[0], scsi_rst_in};
        s_nxt.chip_sync = {s_r.chip_sync[0], scsi_chip_irq};
        s_nxt.cond_prev = cond;

        // APB: ready in the first access cycle, so every transfer is two cycles
        s_nxt.pready = apb_req.psel && !apb_req.penable;
        if (reg_hit(apb_req.paddr, pisw_pkg::IDX_SCSI_IRQ)) begin
            rd = {port_stat, s_r.scsi_rst_st, sense, s_r.scsi_drv, s_r.scsi_en, s_r.scsi_lvl};
        end else if (reg_hit(apb_req.paddr, pisw_pkg::IDX_SLAVE_WIN)) begin
            rd = {s_r.net_sec, s_r.rmc_wait, s_r.win};
        end else if (reg_hit(apb_req.paddr, pisw_pkg::IDX_SOFT_ONE)) begin
            rd = {s_r.sw1_en, 3'h0, s_r.sw1_en, s_r.sw1_lvl};
        end else if (reg_hit(apb_req.paddr, pisw_pkg::IDX_VEC_BASE)) begin
            rd = {s_r.vbase, 4'h0};
        end else if (reg_hit(apb_req.paddr, pisw_pkg::IDX_SOFT_TWO)) begin
            rd = {s_r.sw2_en, 3'h0, s_r.sw2_en, s_r.sw2_lvl};
        end else if (reg_hit(apb_req.paddr, pisw_pkg::IDX_REVISION)) begin
            rd = pisw_pkg::REVISION_LEVEL;
        end else begin
            mapped = 1'b0;
        end
        if (apb_req.psel && !apb_req.penable) begin
            s_nxt.prdata = {24'h00_0000, apb_req.pwrite ? 8'h00 : rd};
            s_nxt.pslverr = !mapped;
        end else if (s_r.pready) begin
            s_nxt.prdata = 32'h0000_0000;
            s_nxt.pslverr = 1'b0;
        end

        // Register writes, taken only at the access edge with ready high
        if (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SCSI_IRQ)) begin
            s_nxt.scsi_lvl = apb_req.pwdata[pisw_pkg::LVL_LSB +: 3];
            s_nxt.scsi_en = apb_req.pwdata[pisw_pkg::EN_BIT];
            s_nxt.scsi_drv = apb_req.pwdata[pisw_pkg::DRV_BIT];
        end
        if (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SLAVE_WIN)) begin
            s_nxt.win = apb_req.pwdata[pisw_pkg::WIN_LSB +: 5];
            s_nxt.rmc_wait = apb_req.pwdata[pisw_pkg::RMC_WAIT_BIT];
            s_nxt.net_sec = apb_req.pwdata[pisw_pkg::NET_LSB +: 2];
        end
        if (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SOFT_ONE)) begin
            s_nxt.sw1_lvl = apb_req.pwdata[pisw_pkg::LVL_LSB +: 3];
            s_nxt.sw1_en = apb_req.pwdata[pisw_pkg::EN_BIT];
        end
        if (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_VEC_BASE)) begin
            s_nxt.vbase = apb_req.pwdata[pisw_pkg::VBASE_LSB +: 4];
        end
        if (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SOFT_TWO)) begin
            s_nxt.sw2_lvl = apb_req.pwdata[pisw_pkg::LVL_LSB +: 3];
            s_nxt.sw2_en = apb_req.pwdata[pisw_pkg::EN_BIT];
        end

        // Reset status: a new edge beats a clear in the same cycle
        if (cond && !s_r.cond_prev) begin
            s_nxt.scsi_rst_st = 1'b1;
        end else if (!s_r.scsi_en || (wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SCSI_IRQ)
                     && apb_req.pwdata[pisw_pkg::RST_ST_BIT])) begin
            s_nxt.scsi_rst_st = 1'b0;
        end

        // Bus reset is open drain: enable only, output level fixed active
        s_nxt.rst_oe = s_r.scsi_drv;

        // Highest level among the requesting sources
        s_nxt.irq_level = lvl_max(src_level(scsi_req, s_r.scsi_lvl),
                                  lvl_max(src_level(sw1_req, s_r.sw1_lvl),
                                          src_level(sw2_req, s_r.sw2_lvl)));

        // Acknowledge: SCSI beats soft one beats soft two at a shared level
        s_nxt.iack_done = iack_req;
        s_nxt.iack_hit = 1'b0;
        s_nxt.iack_vector = 8'h00;
        if (iack_req && (iack_level != 3'h0)) begin
            if (scsi_req && (s_r.scsi_lvl == iack_level)) begin
                s_nxt.iack_hit = 1'b1;
                s_nxt.iack_vector = {s_r.vbase, pisw_pkg::CODE_SCSI};
            end else if (sw1_req && (s_r.sw1_lvl == iack_level)) begin
                s_nxt.iack_hit = 1'b1;
                s_nxt.iack_vector = {s_r.vbase, pisw_pkg::CODE_SOFT_ONE};
            end else if (sw2_req && (s_r.sw2_lvl == iack_level)) begin
                s_nxt.iack_hit = 1'b1;
                s_nxt.iack_vector = {s_r.vbase, pisw_pkg::CODE_SOFT_TWO};
            end
        end

        // Slave window: standard space is 24 bits, so only low windows fit it
        std_win = 5'(vme_addr[23:pisw_pkg::MEM_SHIFT]);
        if (vme_am_ext) begin
            s_nxt.slave_hit = vme_valid && (vme_addr[31:pisw_pkg::MEM_SHIFT] == {5'h00, s_r.win});
        end else begin
            s_nxt.slave_hit = vme_valid && (s_r.win < pisw_pkg::STD_WIN_LIMIT)
                              && (std_win == s_r.win);
        end

        // Network DMA address takes the section bits on top
        s_nxt.net_addr = {s_r.net_sec, net_dma_addr};

        // Locked sequence mastership
        unique case (s_r.rmc_st)
            pisw_pkg::RMC_IDLE: begin
                if (rmc.start) begin
                    if (s_r.rmc_wait || rmc.first_to_vme) begin
                        s_nxt.rmc_st = pisw_pkg::RMC_ACQUIRE;
                    end else begin
                        s_nxt.rmc_st = pisw_pkg::RMC_LOCAL;
                    end
                end
            end
            pisw_pkg::RMC_LOCAL: begin
                if (!rmc.active) begin
                    s_nxt.rmc_st = pisw_pkg::RMC_IDLE;
                end else if (rmc.vme_cycle) begin
                    s_nxt.rmc_st = pisw_pkg::RMC_ACQUIRE;
                end
            end
            pisw_pkg::RMC_ACQUIRE: begin
                if (rmc.granted) begin
                    s_nxt.rmc_st = pisw_pkg::RMC_HELD;
                end
            end
            pisw_pkg::RMC_HELD: begin
                if (!rmc.active) begin
                    s_nxt.rmc_st = pisw_pkg::RMC_IDLE;
                end
            end
        endcase
        // Request stays up while held so no other master slips in mid sequence
        s_nxt.bus_req = (s_nxt.rmc_st == pisw_pkg::RMC_ACQUIRE) || (s_nxt.rmc_st == pisw_pkg::RMC_HELD);
        s_nxt.rmc_go = (s_nxt.rmc_st == pisw_pkg::RMC_LOCAL) || (s_nxt.rmc_st == pisw_pkg::RMC_HELD);
    end

    // ==========================================================
    // State register, all zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register, scsi_rst_out tied high
    assign apb_rsp.prdata = s_r.prdata;
    assign apb_rsp.pready = s_r.pready;
    assign apb_rsp.pslverr = s_r.pslverr;
    assign scsi_rst_out = 1'b1;
    assign scsi_rst_oe = s_r.rst_oe;
    assign irq_level = s_r.irq_level;
    assign iack_done = s_r.iack_done;
    assign iack_hit = s_r.iack_hit;
    assign iack_vector = s_r.iack_vector;
    assign slave_hit = s_r.slave_hit;
    assign net_dma_local_addr = s_r.net_addr;
    assign vme_bus_request = s_r.bus_req;
    assign rmc_go = s_r.rmc_go;

    // ==========================================================
    // Assertions
    default clocking pisw_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_zero_level_quiet: assert property ((s_r.scsi_lvl == 3'h0 && s_r.sw1_lvl == 3'h0 && s_r.sw2_lvl == 3'h0)
        |=> irq_level == 3'h0) else $error("Level zero sources raised a request");
    a_drive_reset_line: assert property ((wr && reg_hit(apb_req.paddr, pisw_pkg::IDX_SCSI_IRQ)
        && apb_req.pwdata[pisw_pkg::DRV_BIT]) |=> ##1 scsi_rst_oe) else $error("Bus reset not driven");
    a_sense_follows: assert property (scsi_rst_in [*3] |=> sense) else $error("Sense missed active reset");
    a_status_edge_set: assert property ($rose(cond) |=> s_r.scsi_rst_st) else $error("Reset status not set");
    a_status_disable_clr: assert property ((!s_r.scsi_en && !cond) |=> !s_r.scsi_rst_st)
        else $error("Reset status survived disable");
    a_scsi_level_req: assert property ((s_r.scsi_en && s_r.scsi_rst_st && s_r.scsi_lvl != 3'h0)
        |=> irq_level >= $past(s_r.scsi_lvl)) else $error("SCSI request below level");
    a_soft_level_req: assert property ((s_r.sw1_en && s_r.sw1_lvl != 3'h0)
        |=> irq_level >= $past(s_r.sw1_lvl)) else $error("Soft one request below level");
    a_iack_scsi_vec: assert property ((iack_req && scsi_req && iack_level == s_r.scsi_lvl)
        |=> iack_hit && iack_vector == {$past(s_r.vbase), pisw_pkg::CODE_SCSI}) else $error("Bad SCSI vector");
    a_rmc_wait_first: assert property ((s_r.rmc_st == pisw_pkg::RMC_IDLE && rmc.start && s_r.rmc_wait)
        |=> !rmc_go && vme_bus_request) else $error("Locked sequence began unmastered");
    a_rmc_hold_bus: assert property ((s_r.rmc_st == pisw_pkg::RMC_HELD && rmc.active)
        |=> vme_bus_request) else $error("Mastership dropped mid sequence");
    a_net_section: assert property (1'b1 |=> net_dma_local_addr[25:24] == $past(s_r.net_sec))
        else $error("Network section bits wrong");

    c_status_set: cover property ($rose(s_r.scsi_rst_st));
    c_iack_soft: cover property (iack_done && iack_hit && iack_vector[3:0] == pisw_pkg::CODE_SOFT_TWO);
    c_rmc_held: cover property (s_r.rmc_st == pisw_pkg::RMC_HELD);
    c_slave_hit: cover property (slave_hit && !$past(vme_am_ext));

endmodule

// [testbench/pisw_far_model.sv]
/* Far side of the block: the SCSI bus reset wire and a VMEbus arbiter.
   Assumes the device drives the reset line only through its enable. */
`timescale 1ns/1ps

module pisw_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rst_oe,
    input wire logic rst_out,
    input wire logic other_rst,
    input wire logic bus_request,
    input wire logic [3:0] delay,
    output logic scsi_rst,
    output logic granted
);
    logic [3:0] wait_r;

    // ==========================================
    // Wired reset line
    // Either party may pull it active; nobody holds it inactive
    assign scsi_rst = (rst_oe & rst_out) | other_rst;

    // ==========================================
    // Arbiter
    // Grant after delay cycles; never taken back while requested
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 4'h0;
        end else if (!bus_request) begin
            wait_r <= 4'h0;
        end else if (wait_r != 4'hf) begin
            wait_r <= wait_r + 4'h1;
        end
    end
    assign granted = bus_request && (wait_r >= delay);
endmodule

// [testbench/pisw_top_bench.sv]
/* Self-checking bench for the interrupt and slave window block.
   Assumes pisw_top beside the far-side model; APB master is the bench. */
`timescale 1ns/1ps

module pisw_top_bench;
    localparam logic [11:0] A_SCSI = {pisw_pkg::IDX_SCSI_IRQ[9:0], 2'b00};
    localparam logic [11:0] A_WIN = {pisw_pkg::IDX_SLAVE_WIN[9:0], 2'b00};
    localparam logic [11:0] A_S1 = {pisw_pkg::IDX_SOFT_ONE[9:0], 2'b00};
    localparam logic [11:0] A_VB = {pisw_pkg::IDX_VEC_BASE[9:0], 2'b00};
    localparam logic [11:0] A_S2 = {pisw_pkg::IDX_SOFT_TWO[9:0], 2'b00};
    localparam logic [11:0] A_REV = {pisw_pkg::IDX_REVISION[9:0], 2'b00};
    pisw_pkg::pisw_apb_req_t req;
    pisw_pkg::pisw_apb_rsp_t rsp;
    pisw_pkg::pisw_rmc_req_t rmc_s;
    logic pclk, presetn, srst, chip_irq, rst_out, rst_oe, oth_rst, iack_req, iack_done, iack_hit;
    logic vv, vext, hit, rs, rf, rv, ra, gnt, breq, go, re;
    logic [2:0] lvl, iack_lvl;
    logic [7:0] vec;
    logic [3:0] dly;
    logic [23:0] naddr;
    logic [25:0] nloc;
    logic [31:0] vaddr, rq, win;
    int num_errors, checks;

    // ==========================================
    // Block and far side
    assign rmc_s = '{rs, rf, rv, ra, gnt};
    pisw_top pisw_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .scsi_rst_in(srst), .scsi_chip_irq(chip_irq), .scsi_rst_out(rst_out), .scsi_rst_oe(rst_oe),
        .irq_level(lvl), .iack_req(iack_req), .iack_level(iack_lvl), .iack_done(iack_done),
        .iack_hit(iack_hit), .iack_vector(vec), .vme_valid(vv), .vme_am_ext(vext), .vme_addr(vaddr),
        .slave_hit(hit), .net_dma_addr(naddr), .net_dma_local_addr(nloc), .rmc(rmc_s),
        .vme_bus_request(breq), .rmc_go(go));
    pisw_far_model pisw_far_model_inst (.pclk(pclk), .presetn(presetn), .rst_oe(rst_oe),
        .rst_out(rst_out), .other_rst(oth_rst), .bus_request(breq), .delay(dly), .scsi_rst(srst),
        .granted(gnt));

    // ==========================================
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (4000) @(posedge pclk);
        num_errors++;
        $display("MISMATCH t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    end

    // ==========================================
    // Shared helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x);
        chk({31'h0, g}, {31'h0, x});
    endtask
    task automatic chk_lvl(input logic [2:0] x);
        chk({29'h0, lvl}, {29'h0, x});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Request held until the rising edge at which pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        // Answer taken at the same edge that completes the access
        rq = rsp.prdata;
        re = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rsp.pready, 1'b1);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rq, {24'h00_0000, e});
    endtask
    task automatic iack(input logic [2:0] l, input logic h, input logic [7:0] v);
        @(posedge pclk);
        iack_req <= 1'b1;
        iack_lvl <= l;
        @(posedge pclk);
        iack_req <= 1'b0;
        @(negedge pclk);
        chk1(iack_done, 1'b1);
        chk1(iack_hit, h);
        chk({24'h0, vec}, {24'h0, v});
    endtask
    task automatic vme(input logic e, input logic [31:0] a, input logic h);
        @(posedge pclk);
        vv <= 1'b1;
        vext <= e;
        vaddr <= a;
        @(posedge pclk);
        vv <= 1'b0;
        @(negedge pclk);
        chk1(hit, h);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs;
        logic [11:0] al [6];
        al = '{A_SCSI, A_WIN, A_S1, A_VB, A_S2, A_REV};
        for (int i = 0; i < 6; i++) begin
            rd(al[i], pisw_pkg::REG_RESET);
        end
        wr(A_REV, 8'hff);
        rd(A_REV, pisw_pkg::REVISION_LEVEL);
        wr(A_VB, 8'hff);
        rd(A_VB, 8'hf0);
        apb(1'b0, 12'h0c0, 8'h00);
        chk1(re, 1'b1);
        $display("t_regs done");
    endtask
    // Whole-value writes only, never read-modify-write
    task automatic t_scsi;
        wr(A_SCSI, 8'h10);
        settle(3);
        chk1(rst_oe, 1'b1);
        rd(A_SCSI, 8'h30);
        wr(A_SCSI, 8'h00);
        settle(3);
        chk1(rst_oe, 1'b0);
        rd(A_SCSI, 8'h00);
        wr(A_VB, 8'h70);
        wr(A_SCSI, 8'h0d);
        @(posedge pclk);
        oth_rst <= 1'b1;
        settle(5);
        rd(A_SCSI, 8'hed);
        chk_lvl(3'h5);
        iack(3'h5, 1'b1, 8'h75);
        wr(A_SCSI, 8'h4d);
        rd(A_SCSI, 8'h2d);
        chk_lvl(3'h0);
        @(posedge pclk);
        chip_irq <= 1'b1;
        settle(4);
        rd(A_SCSI, 8'had);
        chk_lvl(3'h5);
        wr(A_SCSI, 8'h08);
        settle(1);
        chk_lvl(3'h0);
        @(posedge pclk);
        chip_irq <= 1'b0;
        oth_rst <= 1'b0;
        wr(A_SCSI, 8'h0d);
        @(posedge pclk);
        oth_rst <= 1'b1;
        settle(5);
        rd(A_SCSI, 8'hed);
        wr(A_SCSI, 8'h05);
        rd(A_SCSI, 8'h25);
        @(posedge pclk);
        oth_rst <= 1'b0;
        wr(A_SCSI, 8'h00);
        $display("t_scsi done");
    endtask
    task automatic t_soft;
        wr(A_S1, 8'h0b);
        rd(A_S1, 8'h8b);
        chk_lvl(3'h3);
        wr(A_S2, 8'h0b);
        iack(3'h3, 1'b1, 8'h7a);
        wr(A_S2, 8'h0e);
        settle(1);
        chk_lvl(3'h6);
        iack(3'h6, 1'b1, 8'h7b);
        iack(3'h2, 1'b0, 8'h00);
        wr(A_S2, 8'h08);
        rd(A_S2, 8'h88);
        chk_lvl(3'h3);
        wr(A_S1, 8'h03);
        rd(A_S1, 8'h03);
        chk_lvl(3'h0);
        wr(A_S2, 8'h00);
        $display("t_soft done");
    endtask
    task automatic t_win;
        wr(A_WIN, 8'hc2);
        rd(A_WIN, 8'hc2);
        win = 32'h0000_0002 << pisw_pkg::MEM_SHIFT;
        vme(1'b1, win, 1'b1);
        vme(1'b1, win - 32'h0000_0001, 1'b0);
        vme(1'b1, win + (win >> 1) - 32'h0000_0001, 1'b1);
        vme(1'b1, win + (win >> 1), 1'b0);
        vme(1'b0, win, 1'b1);
        wr(A_WIN, 8'h04);
        win = 32'h0000_0004 << pisw_pkg::MEM_SHIFT;
        vme(1'b1, win, 1'b1);
        vme(1'b0, win, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(A_WIN, {2'(s), 6'h00});
            settle(1);
            chk({6'h0, nloc}, {6'h0, 2'(s), naddr});
        end
        vme(1'b0, 32'h003f_fffc, 1'b1);
        $display("t_win done");
    endtask
    // Locked sequence: wait bit w, first cycle remote f, grant delay d
    task automatic rmc_seq(input logic w, input logic f, input logic [3:0] d);
        int n;
        n = 0;
        wr(A_WIN, {2'b00, w, 5'h00});
        @(posedge pclk);
        dly <= d;
        rs <= 1'b1;
        ra <= 1'b1;
        rf <= f;
        @(posedge pclk);
        rs <= 1'b0;
        @(negedge pclk);
        chk1(breq, w | f);
        chk1(go, !(w | f));
        @(posedge pclk);
        rv <= 1'b1;
        settle(1);
        chk1(go, 1'b0);
        while (go !== 1'b1 && n < 20) begin
            settle(0);
            n++;
        end
        chk1(gnt, 1'b1);
        settle(3);
        chk1(go & breq, 1'b1);
        @(posedge pclk);
        ra <= 1'b0;
        rv <= 1'b0;
        settle(1);
        chk1(go | breq, 1'b0);
    endtask
    task automatic t_rmc;
        rmc_seq(1'b1, 1'b0, 4'h4);
        rmc_seq(1'b0, 1'b0, 4'h1);
        rmc_seq(1'b0, 1'b1, 4'h2);
        wr(A_WIN, 8'hff);
        wr(A_S1, 8'h0f);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(A_WIN, 8'h00);
        rd(A_S1, 8'h00);
        $display("t_rmc done");
    endtask
    task automatic stop_test;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        req = '0;
        {chip_irq, oth_rst, iack_req, vv, vext, rs, rf, rv, ra} = 9'h000;
        iack_lvl = 3'h0;
        vaddr = 32'h0000_0000;
        naddr = 24'h12_3456;
        dly = 4'h1;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_scsi();
        t_soft();
        t_win();
        t_rmc();
        stop_test();
    end
endmodule
